// file: inc/ast_cfg.svh
// constants for the audio suspend and talk status block
`ifndef AST_CFG_SVH
`define AST_CFG_SVH
`define AST_SAMPLE_W 8
`define AST_ADDR_W 16
`define AST_SAMPLE_RST 8'h80
`define AST_ADDR_RST 16'h0000
`define AST_SYNC_RST 2'b11
`endif

// file: inc/ast_pkg.sv
// types for the audio suspend and talk status block
`include "ast_cfg.svh"
package ast_pkg;
  typedef enum logic [1:0] {
    AST_IDLE,
    AST_PLAY,
    AST_REC,
    AST_UPLOAD
  } ast_op_t;
  typedef struct packed {
    logic [1:0] sync;
    logic pause;
  } ast_sync_state_t;
endpackage : ast_pkg

// file: hdl/ast_sync.sv
// two-stage synchroniser for the active-low pause pin
`include "ast_cfg.svh"
module ast_sync
  import ast_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic pin_n_i,
  output logic level_n_o
);
  ast_sync_state_t s_q;
  ast_sync_state_t s_d;
  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[0], pin_n_i};
    s_d.pause = 1'b0;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '{sync: `AST_SYNC_RST, pause: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
  assign level_n_o = s_q.sync[1];
endmodule : ast_sync

// file: hdl/ast_core.sv
// pause, resume and talk status control for the channel-0 audio path
// ---------------------------------------------------------------
// What this block does
// - low pause pin holds analog output and playback position
// - pause released, playback continues from the held position
// - pause gates only its own analog channel, serial stream runs on
// - channel-0 pause stops sample capture while recording, resumes after
// - channel-0 pause halts an upload from recording memory
// - talk status asserted while channel 0 plays back, not while recording or uploading
// - talk status polarity selectable high or low
// - talk status follows activity or is set directly by command
// - serial audio sends while its request input is low, holds when high
// ---------------------------------------------------------------
`include "ast_cfg.svh"
module ast_core
  import ast_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic pause_in_n_ch0,
  input wire logic audio_tx_request_n,
  input wire logic [1:0] op_i,
  input wire logic tick_i,
  input wire logic [`AST_SAMPLE_W-1:0] play_sample_i,
  input wire logic [`AST_SAMPLE_W-1:0] adc_sample_i,
  input wire logic talk_high_i,
  input wire logic talk_manual_i,
  input wire logic talk_force_i,
  output logic [`AST_SAMPLE_W-1:0] analog_out_ch0,
  output logic [`AST_ADDR_W-1:0] play_addr_o,
  output logic [`AST_ADDR_W-1:0] rec_addr_o,
  output logic rec_we_o,
  output logic [`AST_SAMPLE_W-1:0] rec_data_o,
  output logic [`AST_ADDR_W-1:0] upload_addr_o,
  output logic upload_valid_o,
  output logic [`AST_SAMPLE_W-1:0] serial_audio_out,
  output logic serial_valid_o,
  output logic talk_active_ch0
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic pause_n_s;
  logic rts_n_s;
  ast_sync u_pause_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_n_i(pause_in_n_ch0),
    .level_n_o(pause_n_s)
  );
  // the request pin comes from off chip too, so it gets the same treatment
  // it resets high, so the serial stream holds for two edges after reset
  ast_sync u_rts_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_n_i(audio_tx_request_n),
    .level_n_o(rts_n_s)
  );
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [`AST_SAMPLE_W-1:0] aout;
    logic [`AST_ADDR_W-1:0] paddr;
    logic [`AST_ADDR_W-1:0] raddr;
    logic rwe;
    logic [`AST_SAMPLE_W-1:0] rdata;
    logic [`AST_ADDR_W-1:0] uaddr;
    logic uvalid;
    logic [`AST_SAMPLE_W-1:0] sout;
    logic svalid;
    logic talk;
  } ast_core_state_t;
  ast_core_state_t st_q;
  ast_core_state_t st_d;
  ast_op_t op;
  logic paused;
  logic active;
  assign op = ast_op_t'(op_i);
  assign paused = !pause_n_s;
  always_comb begin
    st_d = st_q;
    st_d.rwe = 1'b0;
    st_d.uvalid = 1'b0;
    st_d.svalid = 1'b0;
    active = 1'b0;
    case (op)
      AST_PLAY: begin
        active = 1'b1;
        // position only moves when output moves; pause freezes both
        if (tick_i && !paused) begin
          st_d.aout = play_sample_i;
          st_d.paddr = st_q.paddr + 1'b1;
        end
      end
      AST_REC: begin
        if (tick_i && !paused) begin
          st_d.rwe = 1'b1;
          st_d.rdata = adc_sample_i;
          st_d.raddr = st_q.raddr + 1'b1;
        end
      end
      AST_UPLOAD: begin
        if (tick_i && !paused) begin
          st_d.uvalid = 1'b1;
          st_d.uaddr = st_q.uaddr + 1'b1;
        end
      end
      AST_IDLE: begin
        // idle rewinds every position and the output level, whether paused or not
        st_d.paddr = `AST_ADDR_RST;
        st_d.raddr = `AST_ADDR_RST;
        st_d.uaddr = `AST_ADDR_RST;
        st_d.aout = `AST_SAMPLE_RST;
      end
      default: begin
        active = 1'b0;
      end
    endcase
    // serial stream ignores the pause pin entirely
    if (op == AST_PLAY && tick_i && !rts_n_s) begin
      st_d.svalid = 1'b1;
      st_d.sout = play_sample_i;
    end
    st_d.talk = (talk_manual_i ? talk_force_i : active) ~^ talk_high_i;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '{aout: `AST_SAMPLE_RST, paddr: `AST_ADDR_RST, raddr: `AST_ADDR_RST,
                rwe: 1'b0, rdata: `AST_SAMPLE_RST, uaddr: `AST_ADDR_RST, uvalid: 1'b0,
                sout: `AST_SAMPLE_RST, svalid: 1'b0, talk: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end
  assign analog_out_ch0 = st_q.aout;
  assign play_addr_o = st_q.paddr;
  assign rec_addr_o = st_q.raddr;
  assign rec_we_o = st_q.rwe;
  assign rec_data_o = st_q.rdata;
  assign upload_addr_o = st_q.uaddr;
  assign upload_valid_o = st_q.uvalid;
  assign serial_audio_out = st_q.sout;
  assign serial_valid_o = st_q.svalid;
  assign talk_active_ch0 = st_q.talk;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // a tick dropped while paused is harmless: the position did not move,
  // so the source presents the same sample again on the next tick
  sequence paused_tick_s;
    paused && tick_i;
  endsequence
  sequence play_paused_s;
    op == AST_PLAY && paused && tick_i;
  endsequence
  sequence rec_paused_s;
    op == AST_REC && paused && tick_i;
  endsequence
  // pin edges that stay put long enough to reach the second flop
  sequence pin_fall_s;
    $fell(pause_in_n_ch0) ##1 !pause_in_n_ch0;
  endsequence
  sequence pin_rise_s;
    $rose(pause_in_n_ch0) ##1 pause_in_n_ch0;
  endsequence
  play_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    play_paused_s |=> $stable(analog_out_ch0) && $stable(play_addr_o))
    else $error("playback moved while paused");
  play_resume_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (op == AST_PLAY && !paused && tick_i) |=> play_addr_o == $past(play_addr_o) + 1'b1)
    else $error("playback did not step by one on resume");
  play_data_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (op == AST_PLAY && !paused && tick_i) |=> analog_out_ch0 == $past(play_sample_i))
    else $error("playback sample not taken");
  serial_free_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (op == AST_PLAY && tick_i && !rts_n_s) |=> serial_valid_o)
    else $error("serial stream stopped");
  serial_data_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (op == AST_PLAY && tick_i && !rts_n_s) |=> serial_audio_out == $past(play_sample_i))
    else $error("serial sample not taken");
  rec_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rec_paused_s |=> !rec_we_o && $stable(rec_addr_o))
    else $error("capture while paused");
  rec_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (op == AST_REC && !paused && tick_i) |=> rec_we_o && rec_data_o == $past(adc_sample_i)
      && rec_addr_o == $past(rec_addr_o) + 1'b1)
    else $error("capture did not step");
  rec_only_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (op != AST_REC) |=> !rec_we_o)
    else $error("capture outside recording");
  upload_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    paused_tick_s |=> !upload_valid_o)
    else $error("upload while paused");
  upload_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (op == AST_UPLOAD && !paused && tick_i) |=> upload_valid_o
      && upload_addr_o == $past(upload_addr_o) + 1'b1)
    else $error("upload did not step");
  upload_only_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (op != AST_UPLOAD) |=> !upload_valid_o)
    else $error("upload outside upload mode");
  talk_auto_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!talk_manual_i && talk_high_i && op == AST_PLAY) |=> talk_active_ch0)
    else $error("talk status not asserted");
  talk_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!talk_manual_i && talk_high_i && op != AST_PLAY) |=> !talk_active_ch0)
    else $error("talk status asserted while inactive");
  talk_pol_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!talk_manual_i && !talk_high_i && op == AST_PLAY) |=> !talk_active_ch0)
    else $error("talk polarity wrong");
  talk_manual_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    talk_manual_i |=> talk_active_ch0 == ($past(talk_force_i) ~^ $past(talk_high_i)))
    else $error("manual talk status wrong");
  rts_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rts_n_s |=> !serial_valid_o)
    else $error("serial sent while request high");
  sync_delay_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pin_fall_s |=> paused)
    else $error("pause sync latency wrong");
  sync_rise_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pin_rise_s |=> !paused)
    else $error("resume sync latency wrong");
endmodule : ast_core

// file: verif/ast_host.sv
// host-side model driving the pause and send-request pins
module ast_host (
  input wire logic clk_i,
  input wire logic pause_cmd_i,
  input wire logic send_cmd_i,
  output logic pause_in_n_ch0,
  output logic audio_tx_request_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins move after the falling edge, clear of the sampling edge
  always @(negedge clk_i) begin
    pause_in_n_ch0 <= !pause_cmd_i;
    audio_tx_request_n <= !send_cmd_i;
  end
endmodule : ast_host

// file: verif/audio_suspend_talk_status_test.sv
// self-checking bench for the audio suspend and talk status block
module audio_suspend_talk_status_test
  import ast_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'h0, rst_b_i = 1'h0, pc = 1'h0, sc = 1'h1, pn, rn, tick = 1'h0;
  logic th = 1'h1, tm = 1'h0, tf = 1'h0, we, uv, sv, ta;
  logic [1:0] op = 2'h0;
  logic [7:0] ps = 8'h00, as = 8'h00, ao, rd, so;
  logic [15:0] pa, ra, ua;
  int err_total = 0, n_compared = 0;
  always #25 clk_i = ~clk_i;
  ast_host host_u (.clk_i(clk_i), .pause_cmd_i(pc), .send_cmd_i(sc),
    .pause_in_n_ch0(pn), .audio_tx_request_n(rn));
  ast_core dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .pause_in_n_ch0(pn),
    .audio_tx_request_n(rn), .op_i(op), .tick_i(tick), .play_sample_i(ps),
    .adc_sample_i(as), .talk_high_i(th), .talk_manual_i(tm), .talk_force_i(tf),
    .analog_out_ch0(ao), .play_addr_o(pa), .rec_addr_o(ra), .rec_we_o(we),
    .rec_data_o(rd), .upload_addr_o(ua), .upload_valid_o(uv),
    .serial_audio_out(so), .serial_valid_o(sv), .talk_active_ch0(ta));
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one sample strobe; returns at the falling edge where answers stand
  task automatic tk(input ast_op_t o, input logic [7:0] s);
    @(negedge clk_i);
    op <= o;
    tick <= 1'b1;
    ps <= s;
    as <= ~s;
    @(negedge clk_i);
    tick <= 1'b0;
  endtask : tk
  // pins need the model edge plus two synchroniser edges
  task automatic pins(input logic p, input logic s);
    @(negedge clk_i);
    pc <= p;
    sc <= s;
    repeat (5) @(negedge clk_i);
  endtask : pins
  task automatic t_play();
    chk("ao rst", 16'h0080, ao);
    tk(AST_PLAY, 8'h11);
    chk("ao", 16'h0011, ao);
    chk("pa", 16'h0001, pa);
    chk("sv", 16'h0001, sv);
    chk("ta", 16'h0001, ta);
    tk(AST_PLAY, 8'h22);
    chk("pa", 16'h0002, pa);
  endtask : t_play
  task automatic t_pause();
    pins(1, 1);
    tk(AST_PLAY, 8'h33);
    chk("ao held", 16'h0022, ao);
    chk("pa held", 16'h0002, pa);
    chk("so runs", 16'h0033, so);
    pins(0, 1);
    tk(AST_PLAY, 8'h44);
    chk("ao resume", 16'h0044, ao);
    chk("pa resume", 16'h0003, pa);
    pins(0, 0);
    tk(AST_PLAY, 8'h55);
    chk("sv stop", 16'h0000, sv);
    pins(0, 1);
  endtask : t_pause
  task automatic t_rec_up();
    tk(AST_IDLE, 8'h00);
    chk("ta idle", 16'h0000, ta);
    tk(AST_REC, 8'h5a);
    chk("we", 16'h0001, we);
    chk("rd", 16'h00a5, rd);
    pins(1, 1);
    tk(AST_REC, 8'h66);
    chk("we off", 16'h0000, we);
    chk("ra held", 16'h0001, ra);
    tk(AST_UPLOAD, 8'h00);
    chk("uv off", 16'h0000, uv);
    pins(0, 1);
    tk(AST_UPLOAD, 8'h00);
    chk("uv", 16'h0001, uv);
    chk("ua", 16'h0001, ua);
  endtask : t_rec_up
  task automatic t_talk();
    for (int i = 0; i < 4; i++) begin
      th <= i[0];
      tm <= 1'b1;
      tf <= i[1];
      tk(AST_IDLE, 8'h00);
      chk("ta man", {15'h0000, (i[0] ? i[1] : !i[1])}, ta);
    end
    th <= 1'b0;
    tm <= 1'b0;
    tk(AST_PLAY, 8'h77);
    chk("ta low", 16'h0000, ta);
  endtask : t_talk
  initial begin
    repeat (10) @(negedge clk_i);
    rst_b_i = 1'b1;
    // the request flop leaves its reset level two edges after release
    repeat (2) @(negedge clk_i);
    t_play();
    t_pause();
    t_rec_up();
    t_talk();
    // let the last consequents settle before the run ends
    repeat (2) @(negedge clk_i);
    give_verdict();
  end
  // watchdog well past the roughly 80 cycles the scenarios use
  initial begin
    repeat (2000) @(posedge clk_i);
    err_total++;
    give_verdict();
  end
endmodule : audio_suspend_talk_status_test
